// >>> amdc_core.sv
/*
 * amdc_core: digit scaler, memory output and display registers, channel
 * scaler forcing and overflow, phase and busy flags, register port.
 * assumes pin inputs are asynchronous and that pin pulses are wider
 * than two clocks; register strobes are on clk.
 */
// Design decisions made here: the strobed register port and the register offsets.
// Operation
// - decode digit codes five, six, seven
// - backward select is complement of forward
// - each step moves digit scaler one
// - clear command returns digit scaler to zero
// - erase blocks writing ones to memory
// - four-stage output register, true and complement
// - output register is sole readout digit source
// - idle flag lags memory cycle end briefly
// - memory cycle start copies into display register
// - flag when display register is all zero
// - display and output registers form vertical level
// - display register ignored outside analog readout
// - control forces display register first stage
// - overflow follows stage seven, eight or nine
// - analyzer idle when nothing is busy
// - pulser gives four ordered program pulses
// - pulse at end of last arithmetic cycle
// - phase one follows analysis and readout state
// - readout active with complement output
// - force zero and one for stages 5,8,9
// - reload loads first channel of group
// - wrap flag on nine add, zero subtract
`timescale 1ns/1ps
module amdc_core (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // asynchronous pins
  input  wire amdc_pkg::amdc_pins_t pins,
  // digit scaler
  output logic       step_forward_select,
  output logic       step_backward_select,
  output logic [2:0] digit,
  output logic       digit_code_five,
  output logic       digit_code_five_n,
  output logic       digit_code_six,
  output logic       digit_code_seven,
  output logic       digit_code_seven_n,
  // memory and display registers
  output logic [3:0] mem_digit,
  output logic [3:0] mem_digit_n,
  output logic [3:0] write_one,
  output logic [3:0] top_digit_latch,
  output logic       top_digit_zero,
  output logic [7:0] vert_level,
  output logic       digit_wrap_flag,
  // channel scaler
  output logic [8:0] chan,
  output logic       overflow_select,
  output logic       address_wrap_pulse,
  // sequencing and status
  output logic       program_pulse_first,
  output logic       program_pulse_second,
  output logic       program_pulse_third,
  output logic       program_pulse_fourth,
  output logic       last_cycle_end,
  output logic       store_idle_flag,
  output logic       analyzer_idle,
  output logic       phase_one,
  output logic       phase_two,
  output logic       readout_active,
  output logic       readout_active_n
);
  typedef struct packed {
    amdc_pkg::amdc_pins_t meta;
    amdc_pkg::amdc_pins_t pin;
    amdc_pkg::amdc_pins_t prev;
    logic [15:0]          ctrl;
    logic [15:0]          rdata;
    logic [2:0]           digit;
    logic [3:0]           m;
    logic [3:0]           mr;
    logic [8:0]           chan;
    logic [3:0]           wr1;
    logic [7:0]           vert;
    logic                 d5;
    logic                 d6;
    logic                 d7;
    logic                 mr_zero;
    logic                 wrap;
    logic                 ms;
    logic                 ao;
    logic                 last_end;
    logic                 an_idle;
    logic                 ph1;
    logic                 ph2;
    logic                 ro_n;
    logic                 bwd;
    logic                 d5n;
    logic                 d7n;
    logic [3:0]           m_n;
  } amdc_core_state_t;

  amdc_core_state_t s;
  amdc_core_state_t next_s;
  amdc_pulse_if     pif ();

  amdc_pulser u_pulser (
    .clk     (clk),
    .reset_n (reset_n),
    .pif     (pif.gen)
  );

  logic       forward;
  logic       adding;
  logic       subtracting;
  logic       erase;
  logic       analysis;
  logic       readout;
  logic       analog;
  logic [1:0] size;
  logic [1:0] group;
  logic       mem_start;

  assign forward     = s.ctrl[amdc_pkg::C_FORWARD];
  assign adding      = s.ctrl[amdc_pkg::C_ADD];
  assign subtracting = s.ctrl[amdc_pkg::C_SUB];
  assign erase       = s.ctrl[amdc_pkg::C_ERASE];
  assign analysis    = s.ctrl[amdc_pkg::C_ANALYSIS];
  assign readout     = s.ctrl[amdc_pkg::C_READOUT];
  assign analog      = s.ctrl[amdc_pkg::C_ANALOG];
  assign size        = s.ctrl[amdc_pkg::C_SIZE_LO +: 2];
  assign group       = s.ctrl[amdc_pkg::C_GROUP_LO +: 2];
  // a request while a cycle runs is dropped, not queued
  assign mem_start   = s.pin.mem_req & ~s.prev.mem_req & ~pif.busy;
  assign pif.start   = mem_start;

  always_comb begin
    next_s = s;
    // logic reads the second stage and, for edges, the third; never the first
    next_s.meta = pins;
    next_s.pin  = s.meta;
    next_s.prev = s.pin;
    next_s.rdata = 16'h0000;

    if (reg_write && reg_addr == amdc_pkg::CTRL_ADDR) begin
      next_s.ctrl = reg_wdata;
    end
    if (reg_read) begin
      case (reg_addr)
        amdc_pkg::CTRL_ADDR: next_s.rdata = s.ctrl;
        amdc_pkg::STAT_ADDR: next_s.rdata = {s.an_idle, ~pif.busy, s.ph1, s.wrap,
                                             s.digit, s.mr, s.m, 1'b0};
        amdc_pkg::CHAN_ADDR: next_s.rdata = {7'h00, s.chan};
        default:             next_s.rdata = 16'h0000;
      endcase
    end

    // digit scaler; clear wins over a step in the same cycle
    if (s.pin.clear) begin
      next_s.digit = 3'h0;
    end else if (s.pin.step & ~s.prev.step) begin
      next_s.digit = forward ? s.digit + 3'h1 : s.digit - 3'h1;
    end
    next_s.d5 = next_s.digit == amdc_pkg::DIGIT_FIVE;
    next_s.d6 = next_s.digit == amdc_pkg::DIGIT_SIX;
    next_s.d7 = next_s.digit == amdc_pkg::DIGIT_SEVEN;
    next_s.d5n = ~next_s.d5;
    next_s.d7n = ~next_s.d7;

    // memory output register: sense load on the second pulse
    if (pif.pulse[1]) begin
      next_s.m = s.pin.sense;
    end
    // read-in lines only ever set stages
    next_s.m = next_s.m | s.pin.load_in;
    next_s.m_n = ~next_s.m;

    // display register takes the output register at cycle start
    if (pif.pulse[0]) begin
      next_s.mr = s.m;
    end
    if (s.pin.bit0_set) begin
      next_s.mr[0] = 1'b1;
    end
    next_s.mr_zero = next_s.mr == 4'h0;
    // level only meaningful in analog readout
    next_s.vert = (readout & analog) ? {next_s.mr, next_s.m} : 8'h00;

    // restore writes; erase masks every one
    next_s.wr1 = (pif.pulse[2] & ~erase) ? s.m : 4'h0;
    next_s.wrap = (adding & next_s.m == amdc_pkg::DEC_NINE) |
                  (subtracting & next_s.m == 4'h0);

    // channel scaler
    if (s.pin.reload & ~s.prev.reload) begin
      case (size)
        amdc_pkg::SIZE_128: next_s.chan = {group, 7'h00};
        amdc_pkg::SIZE_256: next_s.chan = {group[0], 8'h00};
        default:            next_s.chan = 9'h000;
      endcase
    end else if (s.pin.advance & ~s.prev.advance) begin
      next_s.chan = s.chan + 9'h001;
    end
    // forcing overrides counting; zero wins over one
    next_s.chan[4] = s.pin.force_zero[0] ? 1'b0 : (s.pin.force_one[0] | next_s.chan[4]);
    next_s.chan[7] = s.pin.force_zero[1] ? 1'b0 : (s.pin.force_one[1] | next_s.chan[7]);
    next_s.chan[8] = s.pin.force_zero[2] ? 1'b0 : (s.pin.force_one[2] | next_s.chan[8]);
    case (size)
      amdc_pkg::SIZE_128: next_s.ms = ~next_s.chan[6];
      amdc_pkg::SIZE_256: next_s.ms = ~next_s.chan[7];
      default:            next_s.ms = ~next_s.chan[8];
    endcase
    // wrap only from counting, never from reload
    next_s.ao = s.pin.advance & ~s.prev.advance & ~(s.pin.reload & ~s.prev.reload)
                & ~s.ms & next_s.ms;

    next_s.last_end = pif.pulse[3] & s.pin.last_cycle & (adding | subtracting);
    next_s.an_idle = ~analysis & ~readout & ~pif.busy & ~mem_start;
    next_s.ph1 = analysis | (readout & ~(analog ? s.pin.decade_plot : s.pin.carriage_ret));
    next_s.ph2 = ~next_s.ph1;
    // complements are registered too, so every pin but store_idle_flag leaves a flop
    next_s.bwd = ~next_s.ctrl[amdc_pkg::C_FORWARD];
    next_s.ro_n = ~next_s.ctrl[amdc_pkg::C_READOUT];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
      s.ctrl <= amdc_pkg::CTRL_RESET;
      s.mr_zero <= 1'b1;
      s.an_idle <= 1'b1;
      s.ms <= 1'b1;
      s.d5n <= 1'b1;
      s.d7n <= 1'b1;
      s.m_n <= 4'hf;
      s.ph2 <= 1'b1;
      s.ro_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata            = s.rdata;
  assign step_forward_select  = forward;
  assign step_backward_select = s.bwd;
  assign digit                = s.digit;
  assign digit_code_five      = s.d5;
  assign digit_code_five_n    = s.d5n;
  assign digit_code_six       = s.d6;
  assign digit_code_seven     = s.d7;
  assign digit_code_seven_n   = s.d7n;
  // sole digit source for adder and readout
  assign mem_digit            = s.m;
  assign mem_digit_n          = s.m_n;
  assign write_one            = s.wr1;
  assign top_digit_latch      = s.mr;
  assign top_digit_zero       = s.mr_zero;
  assign vert_level           = s.vert;
  assign digit_wrap_flag      = s.wrap;
  assign chan                 = s.chan;
  assign overflow_select      = s.ms;
  assign address_wrap_pulse   = s.ao;
  assign program_pulse_first  = pif.pulse[0];
  assign program_pulse_second = pif.pulse[1];
  assign program_pulse_third  = pif.pulse[2];
  assign program_pulse_fourth = pif.pulse[3];
  assign last_cycle_end       = s.last_end;
  assign store_idle_flag      = ~pif.busy;
  assign analyzer_idle        = s.an_idle;
  assign phase_one            = s.ph1;
  assign phase_two            = s.ph2;
  assign readout_active       = readout;
  assign readout_active_n     = s.ro_n;

  property p_decode;
    @(posedge clk) disable iff (!reset_n)
      digit_code_five == (digit == 3'h5) && digit_code_seven_n == (digit != 3'h7);
  endproperty
  a_decode: assert property (p_decode)
    else $error("digit decode mismatch");

  property p_step;
    @(posedge clk) disable iff (!reset_n)
      (s.pin.step && !s.prev.step && !s.pin.clear && forward) |=> digit == $past(digit) + 3'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("forward step did not advance by one");

  property p_clear;
    @(posedge clk) disable iff (!reset_n)
      s.pin.clear |=> digit == 3'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("digit scaler not cleared");

  property p_erase;
    @(posedge clk) disable iff (!reset_n)
      erase ##1 erase |-> write_one == 4'h0;
  endproperty
  a_erase: assert property (p_erase)
    else $error("one written during erase");

  property p_copy;
    @(posedge clk) disable iff (!reset_n)
      (program_pulse_first && !s.pin.bit0_set) |=> top_digit_latch == $past(mem_digit);
  endproperty
  a_copy: assert property (p_copy)
    else $error("display register missed the copy");

  property p_zero;
    @(posedge clk) disable iff (!reset_n)
      top_digit_zero == (top_digit_latch == 4'h0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("display zero flag wrong");

  property p_ovf;
    @(posedge clk) disable iff (!reset_n)
      (size == 2'h1) ##1 (size == 2'h1) |-> overflow_select == ~chan[7];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow select on wrong stage");

  property p_wrap;
    @(posedge clk) disable iff (!reset_n)
      (adding && !subtracting) ##1 (mem_digit == 4'h9) |-> digit_wrap_flag;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap flag missing on nine");

  property p_last;
    @(posedge clk) disable iff (!reset_n)
      last_cycle_end |-> $past(program_pulse_fourth);
  endproperty
  a_last: assert property (p_last)
    else $error("last cycle end without fourth pulse");

  property p_complement;
    @(posedge clk) disable iff (!reset_n)
      step_backward_select != step_forward_select && phase_two != phase_one &&
      readout_active_n != readout_active && mem_digit_n == ~mem_digit;
  endproperty
  a_complement: assert property (p_complement)
    else $error("complement output mismatch");

  property p_bit0;
    @(posedge clk) disable iff (!reset_n)
      s.pin.bit0_set |=> top_digit_latch[0];
  endproperty
  a_bit0: assert property (p_bit0)
    else $error("display first stage not forced");
endmodule // amdc_core

// >>> amdc_mem_model.sv
/*
 * amdc_mem_model: memory plane behind the sense amplifiers, one stored digit.
 * assumes the core's first and third program pulses and write_one on clk;
 * the bench presets the digit before a memory cycle.
 */
`timescale 1ns/1ps
module amdc_mem_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // core side
  input  wire logic       pulse_first,
  input  wire logic       pulse_third,
  input  wire logic [3:0] write_one,
  // bench preset
  input  wire logic [3:0] preset,
  input  wire logic       preset_en,
  // sense amplifiers
  output logic      [3:0] sense
);
  logic [3:0] word;
  logic [3:0] data;
  logic       drive;

  // read is destructive: the digit is lost unless the core writes it back
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      word  <= 4'h0;
      data  <= 4'h0;
      drive <= 1'b0;
    end else begin
      if (preset_en) begin
        word <= preset;
      end else if (pulse_first) begin
        word <= 4'h0;
      end else if (|write_one) begin
        word <= word | write_one;
      end
      if (pulse_first) begin
        data  <= word;
        drive <= 1'b1;
      end else if (pulse_third) begin
        drive <= 1'b0;
      end
    end
  end

  // lines float outside the read; show the inverse so stale data never passes
  assign sense = drive ? data : ~data;
endmodule // amdc_mem_model

// >>> amdc_pkg.sv
/*
 * amdc_pkg: constants, field positions and types shared by the
 * analyzer memory and digit control block and its program pulser.
 * assumes a single 40 MHz clock and a synchronous active-low reset.
 */
package amdc_pkg;
  localparam int unsigned CLK_MHZ      = 40;
  // program pulse spacing and memory idle hold, in ns
  localparam int unsigned PULSE_GAP_NS = 100;
  localparam int unsigned IDLE_HOLD_NS = 200;
  localparam logic [3:0]  GAP_CYC      = 4'((PULSE_GAP_NS * CLK_MHZ) / 1000);
  localparam logic [3:0]  HOLD_CYC     = 4'((IDLE_HOLD_NS * CLK_MHZ) / 1000);

  // register offsets
  localparam logic [3:0]  CTRL_ADDR    = 4'h0;
  localparam logic [3:0]  STAT_ADDR    = 4'h1;
  localparam logic [3:0]  CHAN_ADDR    = 4'h2;
  localparam logic [15:0] CTRL_RESET   = 16'h0100;

  // control field positions
  localparam int unsigned C_ADD        = 0;
  localparam int unsigned C_SUB        = 1;
  localparam int unsigned C_ERASE      = 2;
  localparam int unsigned C_ANALYSIS   = 3;
  localparam int unsigned C_READOUT    = 4;
  localparam int unsigned C_ANALOG     = 5;
  localparam int unsigned C_SIZE_LO    = 6;
  localparam int unsigned C_FORWARD    = 8;
  localparam int unsigned C_GROUP_LO   = 9;

  // group size codes
  localparam logic [1:0]  SIZE_128     = 2'h0;
  localparam logic [1:0]  SIZE_256     = 2'h1;

  localparam logic [2:0]  DIGIT_FIVE   = 3'h5;
  localparam logic [2:0]  DIGIT_SIX    = 3'h6;
  localparam logic [2:0]  DIGIT_SEVEN  = 3'h7;
  localparam logic [3:0]  DEC_NINE     = 4'h9;

  typedef enum logic [1:0] {
    PS_IDLE,
    PS_GAP,
    PS_HOLD
  } amdc_pstate_t;

  typedef struct packed {
    logic [3:0] sense;
    logic [3:0] load_in;
    logic       step;
    logic       clear;
    logic       advance;
    logic       reload;
    logic [2:0] force_zero;
    logic [2:0] force_one;
    logic       bit0_set;
    logic       mem_req;
    logic       last_cycle;
    logic       carriage_ret;
    logic       decade_plot;
  } amdc_pins_t;
endpackage

// >>> amdc_pulse_if.sv
/*
 * amdc_pulse_if: link between the control core and the program pulser.
 * assumes both ends on the same clock.
 */
`timescale 1ns/1ps
interface amdc_pulse_if;
  logic       start;
  logic [3:0] pulse;
  logic       busy;
  modport ctl (output start, input pulse, input busy);
  modport gen (input start, output pulse, output busy);
endinterface // amdc_pulse_if

// >>> amdc_pulser.sv
/*
 * amdc_pulser: program pulser; four ordered one-cycle pulses per memory
 * cycle, then a hold before the memory reads idle again.
 * assumes start is a one-cycle pulse on clk.
 */
`timescale 1ns/1ps
module amdc_pulser (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // core side
  amdc_pulse_if.gen pif
);
  typedef struct packed {
    amdc_pkg::amdc_pstate_t st;
    logic [3:0]             cnt;
    logic [1:0]             idx;
    logic [3:0]             pulse;
    logic                   busy;
  } amdc_pulser_state_t;

  amdc_pulser_state_t s;
  amdc_pulser_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.pulse = 4'h0;
    case (s.st)
      amdc_pkg::PS_IDLE: begin
        if (pif.start) begin
          next_s.st = amdc_pkg::PS_GAP;
          next_s.idx = 2'h0;
          next_s.cnt = amdc_pkg::GAP_CYC - 4'h1;
          next_s.pulse = 4'h1;
          next_s.busy = 1'b1;
        end
      end
      amdc_pkg::PS_GAP: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else if (s.idx == 2'h3) begin
          next_s.st = amdc_pkg::PS_HOLD;
          next_s.cnt = amdc_pkg::HOLD_CYC - 4'h1;
        end else begin
          // second through fourth, strictly in order
          next_s.idx = s.idx + 2'h1;
          next_s.pulse = 4'h1 << (s.idx + 2'h1);
          next_s.cnt = amdc_pkg::GAP_CYC - 4'h1;
        end
      end
      amdc_pkg::PS_HOLD: begin
        // idle stays low for the hold after the cycle ends
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else begin
          next_s.st = amdc_pkg::PS_IDLE;
          next_s.busy = 1'b0;
        end
      end
      default: begin
        next_s.st = amdc_pkg::PS_IDLE;
        next_s.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pif.pulse = s.pulse;
  assign pif.busy  = s.busy;

  property p_pulse_order;
    @(posedge clk) disable iff (!reset_n)
      pif.pulse[0] |-> ##4 pif.pulse[1] ##4 pif.pulse[2] ##4 pif.pulse[3];
  endproperty
  a_pulse_order: assert property (p_pulse_order)
    else $error("program pulses out of order or spacing");

  property p_idle_hold;
    @(posedge clk) disable iff (!reset_n)
      pif.pulse[3] |-> pif.busy [*8] ##1 pif.busy ##4 !pif.busy;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("memory busy did not hold after the cycle");
endmodule // amdc_pulser

// >>> tb_analyzer_memory_digit_control.sv
/*
 * tb_analyzer_memory_digit_control: self-checking bench for amdc_core.
 * assumes the memory model as the sense amplifier side and a 40 MHz clock.
 */
`timescale 1ns/1ps
module tb_analyzer_memory_digit_control;
  // clock, reset, register port
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic [3:0]           reg_addr = 4'h0;
  logic [15:0]          reg_wdata = 16'h0000;
  logic                 reg_write = 1'b0;
  logic                 reg_read = 1'b0;
  logic [15:0]          reg_rdata;
  // pins and memory model
  amdc_pkg::amdc_pins_t pin_drv = '0;
  amdc_pkg::amdc_pins_t pins;
  logic [3:0]           sense;
  logic [3:0]           preset = 4'h0;
  logic                 preset_en = 1'b0;
  // observed outputs
  logic                 fwd, bwd, d5, d5n, d6, d7, d7n, tdz, wrap, ovf, awp, p1, p2, p3, p4;
  logic                 lce, m_idle, an_idle, ph1, ph2, ro, ro_n;
  logic [2:0]           digit;
  logic [3:0]           m, m_n, wo, top;
  logic [7:0]           vert;
  logic [8:0]           chan;
  // bench state
  int                   n_fail = 0;
  int                   checks_done = 0;
  int                   cyc = 0;
  int                   n_wrap = 0;
  logic [15:0]          rdv;

  always #12.5 clk = ~clk;

  always_comb begin
    pins = pin_drv;
    pins.sense = sense;
  end

  amdc_core dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pins(pins),
    .step_forward_select(fwd), .step_backward_select(bwd), .digit(digit),
    .digit_code_five(d5), .digit_code_five_n(d5n), .digit_code_six(d6),
    .digit_code_seven(d7), .digit_code_seven_n(d7n), .mem_digit(m), .mem_digit_n(m_n),
    .write_one(wo), .top_digit_latch(top), .top_digit_zero(tdz), .vert_level(vert),
    .digit_wrap_flag(wrap), .chan(chan), .overflow_select(ovf), .address_wrap_pulse(awp),
    .program_pulse_first(p1), .program_pulse_second(p2), .program_pulse_third(p3),
    .program_pulse_fourth(p4), .last_cycle_end(lce), .store_idle_flag(m_idle),
    .analyzer_idle(an_idle), .phase_one(ph1), .phase_two(ph2),
    .readout_active(ro), .readout_active_n(ro_n)
  );

  amdc_mem_model mem (
    .clk(clk), .reset_n(reset_n), .pulse_first(p1), .pulse_third(p3), .write_one(wo),
    .preset(preset), .preset_en(preset_en), .sense(sense)
  );

  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // sample where the edge's updates have landed
  task automatic look(input int n);
    tick(n);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    tick(1);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    tick(1);
    reg_write <= 1'b0;
    look(1);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    tick(1);
    reg_addr <= a;
    reg_read <= 1'b1;
    tick(1);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // pins are synchronised, so each pulse is held three clocks
  task automatic pulse_pin(input int k);
    tick(1);
    case (k)
      0: pin_drv.step <= 1'b1;
      1: pin_drv.clear <= 1'b1;
      2: pin_drv.reload <= 1'b1;
      default: pin_drv.advance <= 1'b1;
    endcase
    tick(3);
    pin_drv.step <= 1'b0;
    pin_drv.clear <= 1'b0;
    pin_drv.reload <= 1'b0;
    pin_drv.advance <= 1'b0;
    look(4);
  endtask

  task automatic mem_cycle(input logic [3:0] top_e, input logic [3:0] m_e, input logic [3:0] wo_e,
                           input logic wrap_e, input logic lce_e);
    int i;
    tick(1);
    pin_drv.mem_req <= 1'b1;
    i = 0;
    while (p1 !== 1'b1 && i < 10) begin
      look(1);
      i++;
    end
    chk("first pulse", 16'(p1), 16'h1);
    pin_drv.mem_req <= 1'b0;
    for (i = 1; i < 26; i++) begin
      look(1);
      chk("pulses", 16'({p1, p2, p3, p4}), 16'({1'b0, i == 4, i == 8, i == 12}));
      chk("store idle", 16'(m_idle), 16'(i >= 24));
      chk("last cycle end", 16'(lce), 16'(lce_e && i == 13));
      chk("write one", 16'(wo), (i == 9) ? 16'(wo_e) : 16'h0);
      if (i == 1) chk("display copy", 16'(top), 16'(top_e));
      if (i == 5) chk("output reg", 16'({m_n, m}), 16'({~m_e, m_e}));
      if (i == 7) chk("wrap", 16'(wrap), 16'(wrap_e));
    end
  endtask

  // hang guard: the tests need well under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (awp === 1'b1) n_wrap <= n_wrap + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    logic [8:0] chan_e [3];
    chan_e = '{9'h180, 9'h100, 9'h000};
    tick(4);
    reset_n <= 1'b1;
    look(1);
    chk("reset flags", 16'({fwd, bwd, d5n, d7n, tdz, an_idle, m_idle, ro_n, ph2, ovf}), 16'h02ff);
    rd(amdc_pkg::CTRL_ADDR, rdv);
    chk("ctrl reset", rdv, amdc_pkg::CTRL_RESET);
    rd(4'hf, rdv);
    chk("unmapped", rdv, 16'h0000);
    for (int i = 1; i < 8; i++) begin
      pulse_pin(0);
      chk("digit up", 16'(digit), 16'(i));
      chk("code five", 16'({d5, d5n}), (i == 5) ? 16'h2 : 16'h1);
      chk("code six", 16'(d6), 16'(i == 6));
      chk("code seven", 16'({d7, d7n}), (i == 7) ? 16'h2 : 16'h1);
    end
    wr(amdc_pkg::CTRL_ADDR, 16'h0000);
    chk("direction", 16'({fwd, bwd}), 16'h1);
    pulse_pin(0);
    chk("digit down", 16'(digit), 16'h6);
    pulse_pin(1);
    chk("digit clear", 16'(digit), 16'h0);
    // memory cycles: add, then subtract with erase
    wr(amdc_pkg::CTRL_ADDR, 16'h0101);
    tick(1);
    preset <= 4'h9;
    preset_en <= 1'b1;
    pin_drv.last_cycle <= 1'b1;
    tick(1);
    preset_en <= 1'b0;
    mem_cycle(4'h0, 4'h9, 4'h9, 1'b1, 1'b1);
    rd(amdc_pkg::STAT_ADDR, rdv);
    chk("status digit", 16'(rdv[8:1]), 16'h09);
    wr(amdc_pkg::CTRL_ADDR, 16'h0106);
    pin_drv.last_cycle <= 1'b0;
    mem_cycle(4'h9, 4'h9, 4'h0, 1'b0, 1'b0);
    chk("display zero", 16'(tdz), 16'h0);
    mem_cycle(4'h9, 4'h0, 4'h0, 1'b1, 1'b0);
    mem_cycle(4'h0, 4'h0, 4'h0, 1'b1, 1'b0);
    chk("display zero", 16'(tdz), 16'h1);
    pin_drv.bit0_set <= 1'b1;
    pin_drv.load_in <= 4'h5;
    look(4);
    chk("bit0 set", 16'({top, tdz}), 16'h02);
    chk("read in", 16'(m), 16'h5);
    pin_drv.load_in <= 4'h0;
    wr(amdc_pkg::CTRL_ADDR, 16'h0130);
    look(3);
    chk("analog flags", 16'({ph1, ph2, ro, ro_n, an_idle}), 16'h14);
    chk("vert level", 16'(vert), 16'h15);
    pin_drv.decade_plot <= 1'b1;
    look(4);
    chk("decade phase", 16'({ph1, ph2}), 16'h1);
    wr(amdc_pkg::CTRL_ADDR, 16'h0110);
    look(3);
    chk("digital phase", 16'({ph1, vert}), 16'h100);
    pin_drv.carriage_ret <= 1'b1;
    look(4);
    chk("carriage phase", 16'({ph1, ph2}), 16'h1);
    pin_drv.carriage_ret <= 1'b0;
    wr(amdc_pkg::CTRL_ADDR, 16'h0108);
    look(3);
    chk("analysis flags", 16'({ph1, ro, ro_n, an_idle}), 16'ha);
    wr(amdc_pkg::CTRL_ADDR, 16'h0100);
    look(3);
    chk("idle", 16'({an_idle, ro}), 16'h2);
    // channel scaler: group reload, stage forcing, overflow select
    for (int s = 0; s < 3; s++) begin
      wr(amdc_pkg::CTRL_ADDR, 16'h0100 | 16'(s << 6) | ((s == 1) ? 16'h0200 : 16'h0600));
      pulse_pin(2);
      chk("reload", 16'(chan), 16'(chan_e[s]));
    end
    pin_drv.force_one <= 3'b111;
    look(4);
    chk("force one", 16'(chan), 16'h0190);
    for (int s = 0; s < 3; s++) begin
      wr(amdc_pkg::CTRL_ADDR, 16'h0100 | 16'(s << 6));
      chk("overflow", 16'(ovf), 16'(s == 0));
    end
    pin_drv.force_zero <= 3'b100;
    look(4);
    chk("force zero", 16'({ovf, chan}), 16'h0290);
    pin_drv.force_zero <= 3'b111;
    look(4);
    chk("force zero all", 16'(chan), 16'h0000);
    pin_drv.force_zero <= 3'b000;
    pin_drv.force_one <= 3'b000;
    look(4);
    // counting up from channel zero at 128 points wraps once, on the last step
    wr(amdc_pkg::CTRL_ADDR, 16'h0100);
    for (int s = 0; s < 128; s++) begin
      if (s == 127) chk("early wrap", 16'(n_wrap), 16'h0);
      pulse_pin(3);
    end
    chk("wrap pulse", 16'(n_wrap), 16'h1);
    chk("chan count", 16'({ovf, chan}), 16'h0280);
    complete_run();
  end
endmodule // tb_analyzer_memory_digit_control
